// >>> bench/swire_properties.sv
// wire-level checks on the link between host end and device end
`include "swire_params.svh"
module swire_properties (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic dev_oe,
  input wire logic host_oe,
  input wire logic line_in
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PDH  = `PRESENCE_HIGH_CYC;
  localparam int PRES = `PRESENCE_LOW_CYC;
  localparam int RDV  = `READ_VALID_CYC;
  localparam int SLOT = `BIT_SLOT_CYC;
  localparam int RSTL = `RESET_LOW_CYC;
  localparam int RDET = `RESET_DETECT_CYC;
  localparam int REC  = 50;
  logic [15:0] dev_run_q;
  logic [15:0] host_run_q;
  logic [15:0] high_run_q;
  logic [15:0] gap_q;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  // run lengths; idle counters saturate so a long quiet line never wraps small
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      dev_run_q  <= '0;
      host_run_q <= '0;
      high_run_q <= 16'hffff;
      gap_q      <= 16'hffff;
    end else begin
      dev_run_q  <= dev_oe ? dev_run_q + 16'h0001 : '0;
      host_run_q <= host_oe ? host_run_q + 16'h0001 : '0;
      high_run_q <= !line_in ? '0 : (&high_run_q ? high_run_q : high_run_q + 16'h0001);
      gap_q      <= (host_oe && host_run_q == 0) ? 16'h0001 :
                    (&gap_q ? gap_q : gap_q + 16'h0001);
    end
  end

  pres_delay_a: assert property ($rose(dev_oe) && !$past(host_oe) |->
    high_run_q inside {[PDH-2:PDH+2]}) else $error("presence delay wrong");
  dev_fall_a: assert property ($rose(dev_oe) && high_run_q < PDH-2 |->
    $past(host_oe)) else $error("device made a falling edge");
  dev_len_a: assert property ($fell(dev_oe) |->
    dev_run_q inside {[RDV-2:SLOT-1], [PRES-1:PRES+1]}) else $error("device low length");
  host_len_a: assert property ($fell(host_oe) |->
    host_run_q inside {[50:749], [3000:SLOT], [RSTL-1:RSTL+1]}) else $error("host low length");
  host_rec_a: assert property ($rose(host_oe) |-> high_run_q >= REC)
    else $error("recovery too short");
  slot_gap_a: assert property ($rose(host_oe) |-> gap_q >= SLOT + REC)
    else $error("slots too close");
  reset_quiet_a: assert property (host_oe && host_run_q > RDET |-> !dev_oe)
    else $error("device drove during reset");
  pres_clear_a: assert property ($rose(dev_oe) && !$past(host_oe) |->
    !host_oe [*8]) else $error("host drove during presence");
endmodule

// >>> bench/tb.sv
// top-level bench: host and device ends joined over the link, byte tests
`include "swire_params.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import swire_pkg::*;
  logic       ref_clk;
  logic       arst_n;
  host_cmd_t  cmd;
  byte_t      cmd_data;
  logic       cmd_valid;
  logic       cmd_ready;
  logic       presence;
  logic       presence_valid;
  byte_t      rx_data;
  logic       rx_valid;
  logic       rx_ready;
  logic       snapshot_trig;
  logic [1:0] nv_op;
  logic       nv_op_valid;
  byte_t      nv_block;
  byte_t      wr_data;
  byte_t      wr_addr;
  logic       wr_valid;
  logic       wr_ready = 1'b0;
  logic [3:0] locked;
  int         num_errors = 0;
  int         tests_run = 0;
  int         cycles = 0;
  int         snaps = 0;
  int         writes = 0;
  byte_t      last_addr;
  byte_t      last_data;
  byte_t      last_block;
  logic [1:0] last_op;
  byte_t      nv_ops [3] = '{`OP_COPY, `OP_RECALL, `OP_LOCK};

  swire_if link ();
  swire_device i_swire_device (.ref_clk(ref_clk), .arst_n(arst_n), .link(link.device),
    .snapshot_trig(snapshot_trig), .nv_op(nv_op), .nv_op_valid(nv_op_valid),
    .nv_block(nv_block), .wr_data(wr_data), .wr_addr(wr_addr), .wr_valid(wr_valid),
    .wr_ready(wr_ready), .locked(locked));
  swire_host i_swire_host (.ref_clk(ref_clk), .arst_n(arst_n), .link(link.host),
    .cmd(cmd), .cmd_data(cmd_data), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .presence(presence), .presence_valid(presence_valid), .rx_data(rx_data),
    .rx_valid(rx_valid), .rx_ready(rx_ready));
  swire_properties i_swire_properties (.ref_clk(ref_clk), .arst_n(arst_n),
    .dev_oe(link.dev_oe), .host_oe(link.host_oe), .line_in(link.line_in));

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  task automatic wrap_up;
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // record device-side strobes; wr_ready toggles so the store path sees stalls
  always @(posedge ref_clk) begin
    cycles++;
    wr_ready <= ~wr_ready;
    if (snapshot_trig === 1'b1) snaps++;
    if (wr_valid === 1'b1 && wr_ready === 1'b1) begin
      writes++;
      last_addr = wr_addr;
      last_data = wr_data;
    end
    if (nv_op_valid === 1'b1) begin
      last_op = nv_op;
      last_block = nv_block;
    end
    if (cycles == 1000000) begin
      num_errors++;
      $display("[FAIL] %0t run timed out", $time);
      wrap_up();
    end
  end

  // one host command, held until the edge where cmd_ready is seen high;
  // waits have no local limit, a hang ends at the cycle ceiling as a failure
  task automatic send(input host_cmd_t c, input byte_t d);
    @(posedge ref_clk);
    cmd <= c;
    cmd_data <= d;
    cmd_valid <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (cmd_ready !== 1'b1);
    cmd_valid <= 1'b0;
  endtask

  task automatic wait_idle;
    @(posedge ref_clk);
    while (cmd_ready !== 1'b1) begin
      @(posedge ref_clk);
    end
  endtask

  task automatic bus_reset;
    send(CMD_RESET, 8'h00);
    while (presence_valid !== 1'b1) begin
      @(posedge ref_clk);
    end
    check({7'h00, presence}, 8'h01, "presence");
  endtask

  task automatic read_byte(input byte_t exp, input string what);
    send(CMD_READ, 8'h00);
    while (rx_valid !== 1'b1) begin
      @(posedge ref_clk);
    end
    check(rx_data, exp, what);
  endtask

  initial begin
    arst_n = 1'b0;
    cmd = CMD_RESET;
    cmd_data = 8'h00;
    cmd_valid = 1'b0;
    rx_ready = 1'b1;
    repeat (3) @(posedge ref_clk);
    arst_n <= 1'b1;
    // write stream of two bytes, second lands at the incremented address
    bus_reset();
    send(CMD_WRITE, `OP_WRITE);
    send(CMD_WRITE, 8'h21);
    send(CMD_WRITE, 8'ha5);
    send(CMD_WRITE, 8'h3c);
    wait_idle();
    check(writes[7:0], 8'h02, "store count");
    check(last_addr, 8'h22, "store address");
    check(last_data, 8'h3c, "store data");
    // read back across the byte boundary
    bus_reset();
    send(CMD_WRITE, `OP_READ);
    send(CMD_WRITE, 8'h21);
    read_byte(8'ha5, "read first");
    read_byte(8'h3c, "read second");
    // sync arms exactly one trigger however many slots follow
    bus_reset();
    send(CMD_WRITE, `OP_SYNC);
    send(CMD_WRITE, 8'h00);
    send(CMD_WRITE, 8'hff);
    send(CMD_WRITE, 8'hff);
    wait_idle();
    check(snaps[7:0], 8'h01, "snapshot count");
    // copy, recall and lock each take only an address byte
    for (int i = 0; i < 3; i++) begin
      bus_reset();
      send(CMD_WRITE, nv_ops[i]);
      send(CMD_WRITE, 8'h45);
      wait_idle();
      check({6'h00, last_op}, i[7:0], "nv op code");
      check(last_block, 8'h40, "nv block");
    end
    check({4'h0, locked}, 8'h04, "locked blocks");
    wrap_up();
  end
endmodule

// >>> pkg/swire_if.sv
// shared single-wire line: each end drives low through its enable
interface swire_if;
  logic dev_oe;
  logic host_oe;
  logic line_in;
  assign line_in = ~(dev_oe | host_oe); // pullup, wired-and
  modport device (output dev_oe, input line_in);
  modport host (output host_oe, input line_in);
endinterface

// >>> pkg/swire_params.svh
// timing constants and opcodes for the single-wire link
`ifndef SWIRE_PARAMS_SVH
`define SWIRE_PARAMS_SVH
`define CLK_MHZ            50
`define RESET_LOW_US       480
`define RESET_DETECT_US    120
`define PRESENCE_HIGH_US   30
`define PRESENCE_LOW_US    120
`define BIT_SLOT_US        70
`define SLOT_RECOVERY_US   2
`define WRITE_ONE_LOW_US   6
`define WRITE_ZERO_LOW_US  65
`define READ_VALID_US      15
`define MASTER_SAMPLE_US   12
`define DEV_SAMPLE_US      30
`define PRES_SAMPLE_US     15
`define READ_START_US      1
`define RESET_LOW_CYC      (`RESET_LOW_US * `CLK_MHZ)
`define RESET_DETECT_CYC   (`RESET_DETECT_US * `CLK_MHZ)
`define PRESENCE_HIGH_CYC  (`PRESENCE_HIGH_US * `CLK_MHZ)
`define PRESENCE_LOW_CYC   (`PRESENCE_LOW_US * `CLK_MHZ)
`define BIT_SLOT_CYC       (`BIT_SLOT_US * `CLK_MHZ)
`define SLOT_RECOVERY_CYC  (`SLOT_RECOVERY_US * `CLK_MHZ)
`define WRITE_ONE_LOW_CYC  (`WRITE_ONE_LOW_US * `CLK_MHZ)
`define WRITE_ZERO_LOW_CYC (`WRITE_ZERO_LOW_US * `CLK_MHZ)
`define READ_VALID_CYC     (`READ_VALID_US * `CLK_MHZ)
`define MASTER_SAMPLE_CYC  (`MASTER_SAMPLE_US * `CLK_MHZ)
`define DEV_SAMPLE_CYC     (`DEV_SAMPLE_US * `CLK_MHZ)
`define PRES_SAMPLE_CYC    (`PRES_SAMPLE_US * `CLK_MHZ)
`define READ_START_CYC     (`READ_START_US * `CLK_MHZ)
`define RESET_SEQ_CYC      (2 * `RESET_LOW_CYC)
`define OP_READ            8'h69
`define OP_WRITE           8'h6c
`define OP_COPY            8'h48
`define OP_RECALL          8'hb8
`define OP_LOCK            8'h6a
`define OP_SYNC            8'hd2
`define ADDR_TOP           8'hff
`define FIFO_DEPTH         32
`define MEM_WORDS          256
`endif

// >>> pkg/swire_pkg.sv
// shared types for the single-wire link
package swire_pkg;
  typedef logic [7:0]  byte_t;
  typedef logic [15:0] cnt_t;
  typedef enum logic [1:0] {
    CMD_RESET,
    CMD_WRITE,
    CMD_READ
  } host_cmd_t;
endpackage

// >>> verilog/swire_device.sv
// device end: reset/presence, bit slots, function commands, memory
// Summary of operation
// - sync then the rise closing the first slot fires snapshot
// - master resends sync for each snapshot
// - read opcode streams memory from address
// - write opcode stores bytes from address
// - copy/recall/lock: address only, lock permanent
// - master starts with reset-low then releases
// - after reset rise wait, then presence pulse
// - only presence falls driven by device
// - master keeps slot time and recovery
// - write one releases line early
// - write zero holds line low
// - device samples mid-slot, high is one
// - read slot starts with short master low
// - device zero holds low past read-valid
// - device one leaves line released
// - master samples before read-valid time
// - long low line means reset
// - read past top address gives ones
`include "swire_params.svh"
module swire_device (
  input  wire logic     ref_clk,
  input  wire logic     arst_n,
  swire_if.device       link,
  output logic          snapshot_trig,
  output logic [1:0]    nv_op,
  output logic          nv_op_valid,
  output swire_pkg::byte_t nv_block,
  output swire_pkg::byte_t wr_data,
  output swire_pkg::byte_t wr_addr,
  output logic          wr_valid,
  input  wire logic     wr_ready,
  output logic [3:0]    locked
);
  import swire_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE, ST_PRES_WAIT, ST_PRES_LOW, ST_OPCODE, ST_ADDR, ST_READ, ST_WRITE, ST_SYNC
  } dev_st_t;

  typedef struct packed {
    dev_st_t st;
    cnt_t    low_cnt;
    cnt_t    tmr;
    logic    in_slot;
    logic    line_d;
    logic    drive;
    logic [2:0] bitn;
    byte_t   sh;
    byte_t   op;
    byte_t   addr;
    logic    past_top;
    logic    trig;
    logic    sync_fall;
    logic [1:0] nv;
    logic    nv_v;
    byte_t   blk;
    byte_t   wd;
    byte_t   wa;
    logic    wv;
    logic [3:0] lk;
  } dev_state_t;

  dev_state_t s_q;
  dev_state_t s_d;
  byte_t mem [`MEM_WORDS];
  byte_t rd_byte;
  logic  fall;
  logic  rise;
  logic  sample;
  logic  wr_store;

  assign fall    = s_q.line_d & ~link.line_in;
  assign rise    = ~s_q.line_d & link.line_in;
  assign rd_byte = s_q.past_top ? 8'hff : mem[s_q.addr];
  assign sample  = s_q.in_slot && (s_q.tmr == cnt_t'(`DEV_SAMPLE_CYC));

  // next-state logic for the whole device
  always_comb begin
    logic [7:0] nsh;
    nsh = {link.line_in, s_q.sh[7:1]};
    s_d = s_q;
    wr_store = 1'b0;
    s_d.line_d = link.line_in;
    s_d.trig = 1'b0;
    s_d.nv_v = 1'b0;
    if (s_q.wv && wr_ready) s_d.wv = 1'b0;
    // only master lows count: our own presence lasts as long as the detect time
    s_d.low_cnt = (link.line_in || s_q.drive) ? '0 : s_q.low_cnt + 1'b1;
    if (s_q.in_slot) s_d.tmr = s_q.tmr + 1'b1;
    if (s_q.in_slot && s_q.tmr == cnt_t'(`BIT_SLOT_CYC)) s_d.in_slot = 1'b0;
    // read zero is held to read-valid; presence has its own timer, so gate by slot
    if (s_q.in_slot && s_q.drive && s_q.tmr >= cnt_t'(`READ_VALID_CYC)) s_d.drive = 1'b0;
    case (s_q.st)
      ST_IDLE: ;
      ST_PRES_WAIT: begin
        s_d.tmr = s_q.tmr + 1'b1;
        if (s_q.tmr == cnt_t'(`PRESENCE_HIGH_CYC)) begin
          s_d.st = ST_PRES_LOW;
          s_d.tmr = '0;
          s_d.drive = 1'b1;
        end
      end
      ST_PRES_LOW: begin
        s_d.tmr = s_q.tmr + 1'b1;
        if (s_q.tmr == cnt_t'(`PRESENCE_LOW_CYC)) begin
          s_d.drive = 1'b0;
          s_d.st = ST_OPCODE;
          s_d.tmr = '0;
          s_d.bitn = '0;
        end
      end
      default: begin
        // every slot opens on a master falling edge
        if (fall && !s_q.in_slot) begin
          s_d.in_slot = 1'b1;
          s_d.tmr = '0;
          if (s_q.st == ST_READ) s_d.drive = ~rd_byte[s_q.bitn];
          if (s_q.st == ST_SYNC) s_d.sync_fall = 1'b1;
        end
        // fire on the rise closing the first armed slot, not the address byte's last rise
        if (s_q.st == ST_SYNC && s_q.sync_fall && rise) begin
          s_d.trig = 1'b1;
          s_d.sync_fall = 1'b0;
          s_d.st = ST_IDLE;
        end
        if (sample) begin
          s_d.sh = nsh;
          s_d.bitn = s_q.bitn + 1'b1;
          if (s_q.bitn == 3'd7) begin
            case (s_q.st)
              ST_OPCODE: begin
                s_d.op = nsh;
                s_d.st = (nsh == `OP_READ || nsh == `OP_WRITE || nsh == `OP_COPY ||
                          nsh == `OP_RECALL || nsh == `OP_LOCK || nsh == `OP_SYNC)
                         ? ST_ADDR : ST_IDLE;
              end
              ST_ADDR: begin
                s_d.addr = nsh;
                s_d.past_top = 1'b0;
                s_d.st = ST_IDLE;
                if (s_q.op == `OP_READ) s_d.st = ST_READ;
                if (s_q.op == `OP_WRITE) s_d.st = ST_WRITE;
                if (s_q.op == `OP_SYNC) s_d.st = ST_SYNC;
                if (s_q.op == `OP_COPY || s_q.op == `OP_RECALL || s_q.op == `OP_LOCK) begin
                  s_d.nv_v = 1'b1;
                  s_d.blk = {nsh[7:5], 5'h00};
                  s_d.nv = (s_q.op == `OP_COPY) ? 2'd0 : (s_q.op == `OP_RECALL) ? 2'd1 : 2'd2;
                  if (s_q.op == `OP_LOCK) s_d.lk[nsh[6:5]] = 1'b1;
                end
              end
              ST_READ, ST_WRITE: begin
                if (s_q.st == ST_WRITE && !s_q.past_top && !s_q.lk[s_q.addr[6:5]]) begin
                  wr_store = 1'b1;
                  s_d.wd = nsh;
                  s_d.wa = s_q.addr;
                  s_d.wv = 1'b1;
                end
                if (s_q.addr == `ADDR_TOP) s_d.past_top = 1'b1;
                s_d.addr = s_q.addr + 1'b1;
              end
              default: ;
            endcase
          end
        end
      end
    endcase
    // long low is a reset wherever we are; rise after it gives presence
    if (s_q.low_cnt >= cnt_t'(`RESET_DETECT_CYC)) begin
      s_d.st = ST_IDLE;
      s_d.drive = 1'b0;
      s_d.in_slot = 1'b0;
      s_d.sync_fall = 1'b0;
      s_d.low_cnt = s_q.low_cnt; // saturate
      if (link.line_in) s_d.low_cnt = '0;
    end
    if (rise && s_q.low_cnt >= cnt_t'(`RESET_DETECT_CYC) && !s_q.drive) begin
      s_d.st = ST_PRES_WAIT;
      s_d.tmr = '0;
    end
  end

  // one register for all state
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '{st: ST_IDLE, line_d: 1'b1, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  // local memory copy so reads return what was written
  always_ff @(posedge ref_clk) begin
    if (wr_store) mem[s_q.addr] <= s_d.wd;
  end

  assign link.dev_oe   = s_q.drive;
  assign snapshot_trig = s_q.trig;
  assign nv_op         = s_q.nv;
  assign nv_op_valid   = s_q.nv_v;
  assign nv_block      = s_q.blk;
  assign wr_data       = s_q.wd;
  assign wr_addr       = s_q.wa;
  assign wr_valid      = s_q.wv;
  assign locked        = s_q.lk;
endmodule

// >>> verilog/swire_host.sv
// host end: generates reset, write and read slots; received bytes via fifo
`include "swire_params.svh"
module swire_host (
  input  wire logic       ref_clk,
  input  wire logic       arst_n,
  swire_if.host           link,
  input  swire_pkg::host_cmd_t cmd,
  input  swire_pkg::byte_t     cmd_data,
  input  wire logic       cmd_valid,
  output logic            cmd_ready,
  output logic            presence,
  output logic            presence_valid,
  output swire_pkg::byte_t rx_data,
  output logic            rx_valid,
  input  wire logic       rx_ready
);
  import swire_pkg::*;

  typedef enum logic [1:0] {H_IDLE, H_RESET, H_SLOT, H_REC} host_st_t;

  typedef struct packed {
    host_st_t  st;
    host_cmd_t cmd;
    cnt_t      tmr;
    logic [2:0] bitn;
    byte_t     sh;
    logic      drive;
    logic      pres;
    logic      pres_v;
    logic      push;
  } host_state_t;

  host_state_t s_q;
  host_state_t s_d;
  logic        fifo_ready;
  logic        low_end;

  // low phase length: write bit chooses short or long, read uses the shorter read-start low
  always_comb begin
    low_end = 1'b0;
    if (s_q.cmd == CMD_WRITE && s_q.sh[0])
      low_end = s_q.tmr == cnt_t'(`WRITE_ONE_LOW_CYC);
    else if (s_q.cmd == CMD_WRITE)
      low_end = s_q.tmr == cnt_t'(`WRITE_ZERO_LOW_CYC);
    else
      low_end = s_q.tmr == cnt_t'(`READ_START_CYC);
  end

  assign cmd_ready = (s_q.st == H_IDLE) && (cmd != CMD_READ || fifo_ready);

  // sequencer
  always_comb begin
    s_d = s_q;
    s_d.pres_v = 1'b0;
    s_d.push = 1'b0;
    s_d.tmr = s_q.tmr + 1'b1;
    case (s_q.st)
      H_IDLE: begin
        s_d.tmr = '0;
        if (cmd_valid && cmd_ready) begin
          s_d.cmd = cmd;
          s_d.sh = cmd_data;
          s_d.bitn = '0;
          s_d.drive = 1'b1;
          s_d.st = (cmd == CMD_RESET) ? H_RESET : H_SLOT;
        end
      end
      H_RESET: begin
        if (s_q.tmr == cnt_t'(`RESET_LOW_CYC)) s_d.drive = 1'b0;
        if (s_q.tmr == cnt_t'(`RESET_LOW_CYC + `PRESENCE_HIGH_CYC + `PRES_SAMPLE_CYC))
          s_d.pres = ~link.line_in;
        if (s_q.tmr == cnt_t'(`RESET_SEQ_CYC)) begin
          s_d.pres_v = 1'b1;
          s_d.st = H_IDLE;
        end
      end
      H_SLOT: begin
        if (s_q.drive && low_end) s_d.drive = 1'b0;
        // master sample just before read-valid
        if (s_q.cmd == CMD_READ && s_q.tmr == cnt_t'(`MASTER_SAMPLE_CYC))
          s_d.sh = {link.line_in, s_q.sh[7:1]};
        if (s_q.tmr == cnt_t'(`BIT_SLOT_CYC)) begin
          s_d.drive = 1'b0;
          s_d.tmr = '0;
          if (s_q.cmd == CMD_WRITE) s_d.sh = {1'b0, s_q.sh[7:1]};
          s_d.st = H_REC;
        end
      end
      H_REC: begin
        if (s_q.tmr == cnt_t'(`SLOT_RECOVERY_CYC) && link.line_in) begin
          s_d.tmr = '0;
          s_d.bitn = s_q.bitn + 1'b1;
          if (s_q.bitn == 3'd7) begin
            s_d.st = H_IDLE;
            s_d.push = (s_q.cmd == CMD_READ);
          end else begin
            s_d.st = H_SLOT;
            s_d.drive = 1'b1;
          end
        end else if (s_q.tmr == cnt_t'(`SLOT_RECOVERY_CYC)) begin
          s_d.tmr = s_q.tmr;
        end
      end
      default: s_d.st = H_IDLE;
    endcase
  end

  // one register for all state
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) s_q <= '{st: H_IDLE, cmd: CMD_RESET, default: '0};
    else s_q <= s_d;
  end

  sync_fifo #(.WIDTH(8), .DEPTH(`FIFO_DEPTH)) rx_fifo (
    .ref_clk   (ref_clk),
    .arst_n    (arst_n),
    .in_data   (s_q.sh),
    .in_valid  (s_q.push),
    .in_ready  (fifo_ready),
    .out_data  (rx_data),
    .out_valid (rx_valid),
    .out_ready (rx_ready)
  );

  assign link.host_oe   = s_q.drive;
  assign presence       = s_q.pres;
  assign presence_valid = s_q.pres_v;
endmodule

// >>> verilog/sync_fifo.sv
// parameterised synchronous fifo with valid/ready on both sides
module sync_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input  wire logic             ref_clk,
  input  wire logic             arst_n,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_q;
  logic [AW:0]      rd_q;
  logic             push;
  logic             pop;

  // full when pointers differ only in the wrap bit
  assign in_ready  = (wr_q[AW-1:0] != rd_q[AW-1:0]) || (wr_q[AW] == rd_q[AW]);
  assign out_valid = (wr_q != rd_q);
  assign out_data  = mem[rd_q[AW-1:0]];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // pointer registers
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) wr_q <= wr_q + 1'b1;
      if (pop)  rd_q <= rd_q + 1'b1;
    end
  end

  // storage has no reset, data is qualified by valid
  always_ff @(posedge ref_clk) begin
    if (push) mem[wr_q[AW-1:0]] <= in_data;
  end
endmodule
